// *** design/sidrl_params.svh ***
`ifndef SIDRL_PARAMS_SVH
`define SIDRL_PARAMS_SVH

// Register indices.
`define SIDRL_IDX_REV_VENDOR 8'h05
`define SIDRL_IDX_DEVICE 8'h06
`define SIDRL_IDX_LENGTH 8'h07
`define SIDRL_IDX_SPARE 8'h08

// Field positions.
`define SIDRL_LEN_MSB 4
`define SIDRL_REV_LSB 4

// Reset values.
`define SIDRL_LENGTH_RESET 5'h08
`define SIDRL_SPARE_VALUE 8'h00

// Output enable latency in output clock cycles.
`define SIDRL_OE_LAT_MIN 4
`define SIDRL_OE_LAT_MAX 12

`endif

// *** design/sidrl_pkg.sv ***
package sidrl_pkg;

   // Register access request from the serial front end.
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] index;
      logic [7:0] wdata;
   } sidrl_req_t;

   // Block read sequencing states.
   typedef enum logic [1:0] {
      SIDRL_IDLE,
      SIDRL_COUNT,
      SIDRL_DATA
   } sidrl_state_t;

endpackage

// *** design/sidrl_oe_delay.sv ***
`timescale 1ns/1ps
`include "sidrl_params.svh"

// Synchronises an active-low output enable pin and applies it after a fixed delay.
module sidrl_oe_delay #(
   parameter int DELAY = 6
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic oe_pin_n,
   output logic out_enable
);
   logic sync1;
   logic sync2;
   logic [DELAY-1:0] pipe;
   logic [DELAY-1:0] next_pipe;

   // The pipe shifts the synchronised enable towards the output.
   always_comb begin
      next_pipe = {pipe[DELAY-2:0], ~sync2};
   end

   // Two-stage synchroniser followed by the delay pipe.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sync1 <= 1'b1;
         sync2 <= 1'b1;
         pipe <= '0;
         out_enable <= 1'b0;
      end else begin
         sync1 <= oe_pin_n;
         sync2 <= sync1;
         pipe <= next_pipe;
         out_enable <= pipe[DELAY-1];
      end
   end
endmodule

// *** design/sidrl_regs.sv ***
`timescale 1ns/1ps
`include "sidrl_params.svh"

// Notes on behaviour
// - Index 6 returns the fixed device code and ignores writes.
// - Index 7 bits 4..0 are host writable and set the block read length.
// - The length field resets to 8, giving nine bytes, from the start index up to eight past it.
// - An output enable pin change reaches its output after 4 to 12 output clock cycles.
// - Index 5 is read-only with revision code in bits 7..4 and maker code in bits 3..0.
module sidrl_regs #(
   parameter logic [7:0] DEVICE_CODE = 8'h5A, // Arbitrary value.
   parameter logic [3:0] REVISION_CODE = 4'h3, // Arbitrary value.
   parameter logic [3:0] MAKER_CODE = 4'h7, // Arbitrary value.
   parameter int OE_DELAY = 6,
   parameter int OE_CHANNELS = 2
) (
   input wire logic clock,
   input wire logic rst_n,
   input sidrl_pkg::sidrl_req_t req,
   input wire logic block_start,
   input wire logic byte_take,
   input wire logic [OE_CHANNELS-1:0] oe_pin_n,
   output logic [7:0] rdata,
   output logic rdata_valid,
   output logic [4:0] readback_length,
   output logic [OE_CHANNELS-1:0] diff_clock_out_en
);
   // Stored length field; the output port carries a registered copy of it.
   logic [4:0] length_q;
   logic [4:0] next_length;
   logic length_write;

   // Block read sequencer: phase, next index to fetch and bytes still owed.
   sidrl_pkg::sidrl_state_t state;
   sidrl_pkg::sidrl_state_t next_state;
   logic [7:0] ptr;
   logic [7:0] next_ptr;
   logic [5:0] left;
   logic [5:0] next_left;

   // Read data path.
   logic [7:0] next_rdata;
   logic next_valid;
   logic [7:0] fetch_index;
   logic [7:0] fetch_byte;

   // Decoded events of the current cycle.
   logic idle_read;
   logic seq_start;
   logic seq_fetch;
   logic seq_finish;

   // Chooses which index feeds the read decode.
   // In idle a single read looks at the request; during a block read the pointer leads.
   always_comb begin
      fetch_index = ptr;
      if (state == sidrl_pkg::SIDRL_IDLE) begin
         fetch_index = req.index;
      end
   end

   // Register read decode.
   // Unmapped and reserved indices read as zero so a block read past the bank stays harmless.
   always_comb begin
      fetch_byte = 8'h00;
      case (fetch_index)
         `SIDRL_IDX_REV_VENDOR: begin
            fetch_byte = {REVISION_CODE, MAKER_CODE};
         end
         `SIDRL_IDX_DEVICE: begin
            fetch_byte = DEVICE_CODE;
         end
         `SIDRL_IDX_LENGTH: begin
            fetch_byte = {3'h0, length_q};
         end
         `SIDRL_IDX_SPARE: begin
            fetch_byte = `SIDRL_SPARE_VALUE;
         end
         default: begin
            fetch_byte = 8'h00;
         end
      endcase
   end

   // Event decode.
   // A block start wins over a plain read in idle, so the host never sees both answers at once.
   always_comb begin
      idle_read = 1'b0;
      seq_start = 1'b0;
      seq_fetch = 1'b0;
      seq_finish = 1'b0;
      unique case (state)
         sidrl_pkg::SIDRL_IDLE: begin
            seq_start = block_start;
            idle_read = req.rd && !block_start;
         end
         sidrl_pkg::SIDRL_COUNT: begin
            seq_fetch = byte_take;
         end
         sidrl_pkg::SIDRL_DATA: begin
            seq_fetch = byte_take && (left != 6'h00);
            seq_finish = byte_take && (left == 6'h00);
         end
         default: begin
            seq_finish = 1'b1;
         end
      endcase
   end

   // Length write detection.
   // Only index 7 takes writes; indices 5, 6 and 8 silently drop them.
   always_comb begin
      length_write = req.wr && (req.index == `SIDRL_IDX_LENGTH);
   end

   // Next value of the length field.
   // Bits 7 to 5 of the written byte are reserved and never stored.
   always_comb begin
      next_length = length_q;
      if (length_write) begin
         next_length = req.wdata[`SIDRL_LEN_MSB:0];
      end
   end

   // Length field register and its port copy.
   // The copy is loaded from the same next value so both always agree.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         length_q <= `SIDRL_LENGTH_RESET;
         readback_length <= `SIDRL_LENGTH_RESET;
      end else begin
         length_q <= next_length;
         readback_length <= next_length;
      end
   end

   // Next values of the block read sequencer.
   // The count byte is the field itself; field plus one data bytes follow it.
   always_comb begin
      next_state = state;
      next_ptr = ptr;
      next_left = left;
      unique case (state)
         sidrl_pkg::SIDRL_IDLE: begin
            if (seq_start) begin
               next_ptr = req.index;
               next_left = {1'b0, length_q} + 6'h01;
               next_state = sidrl_pkg::SIDRL_COUNT;
            end
         end
         sidrl_pkg::SIDRL_COUNT: begin
            if (seq_fetch) begin
               next_ptr = ptr + 8'h01;
               next_left = left - 6'h01;
               next_state = sidrl_pkg::SIDRL_DATA;
            end
         end
         sidrl_pkg::SIDRL_DATA: begin
            if (seq_fetch) begin
               next_ptr = ptr + 8'h01;
               next_left = left - 6'h01;
            end else if (seq_finish) begin
               next_state = sidrl_pkg::SIDRL_IDLE;
            end
         end
         default: begin
            next_state = sidrl_pkg::SIDRL_IDLE;
         end
      endcase
   end

   // Sequencer registers.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= sidrl_pkg::SIDRL_IDLE;
         ptr <= 8'h00;
         left <= 6'h00;
      end else begin
         state <= next_state;
         ptr <= next_ptr;
         left <= next_left;
      end
   end

   // Next values of the read data path.
   // Data holds until the next read or take, so the host may sample it late.
   always_comb begin
      next_rdata = rdata;
      next_valid = rdata_valid;
      if (seq_start) begin
         next_rdata = {3'h0, length_q};
         next_valid = 1'b1;
      end else if (idle_read || seq_fetch) begin
         next_rdata = fetch_byte;
         next_valid = 1'b1;
      end else if (seq_finish) begin
         next_valid = 1'b0;
      end
   end

   // Read data registers.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 8'h00;
         rdata_valid <= 1'b0;
      end else begin
         rdata <= next_rdata;
         rdata_valid <= next_valid;
      end
   end

   // One delayed enable per output enable pin.
   for (genvar i = 0; i < OE_CHANNELS; i++) begin : g_oe
      sidrl_oe_delay #(
         .DELAY(OE_DELAY)
      ) u_oe (
         .clock(clock),
         .rst_n(rst_n),
         .oe_pin_n(oe_pin_n[i]),
         .out_enable(diff_clock_out_en[i])
      );
   end
endmodule

// *** bench/sidrl_regs_monitor.sv ***
`timescale 1ns/1ps
// Ties the index 5, index 6 and count byte answers to their requests; also checks length writes and enable latency.
module sidrl_regs_monitor #(
   parameter logic [7:0] DEVICE_CODE = 8'h5A,
   parameter logic [7:0] REV_MAKER = 8'h37,
   parameter int OE_CHANNELS = 2
) (
   input wire logic clock,
   input wire logic rst_n,
   input sidrl_pkg::sidrl_req_t req,
   input wire logic block_start,
   input wire logic byte_take,
   input wire logic [OE_CHANNELS-1:0] oe_pin_n,
   input wire logic [7:0] rdata,
   input wire logic rdata_valid,
   input wire logic [4:0] readback_length,
   input wire logic [OE_CHANNELS-1:0] diff_clock_out_en
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // The enable must not follow the pin too early.
   sequence en_off_s;
      !diff_clock_out_en[0] [*4];
   endsequence
   dev_code_a: assert property (req.rd && req.index == 8'h06 |=> rdata == DEVICE_CODE)
      else $error("device code wrong");
   rev_code_a: assert property (req.rd && req.index == 8'h05 |=> rdata == REV_MAKER)
      else $error("revision byte wrong");
   len_write_a: assert property (req.wr && req.index == 8'h07 |=> readback_length == $past(req.wdata[4:0]))
      else $error("length not written");
   len_keep_a: assert property (!(req.wr && req.index == 8'h07) |=> $stable(readback_length))
      else $error("length changed");
   count_first_a: assert property (block_start |=> rdata_valid && rdata == {3'h0, readback_length})
      else $error("count byte wrong");
   oe_latency_a: assert property ($fell(oe_pin_n[0]) |-> en_off_s ##[1:9] diff_clock_out_en[0])
      else $error("enable latency wrong");
endmodule

bind sidrl_regs sidrl_regs_monitor #(.DEVICE_CODE(DEVICE_CODE), .REV_MAKER({REVISION_CODE, MAKER_CODE}),
   .OE_CHANNELS(OE_CHANNELS)) u_mon (.*);

// *** bench/sidrl_host.sv ***
`timescale 1ns/1ps
// Host controller model: one request per call, held for one edge.
module sidrl_host (
   input wire logic clock,
   output sidrl_pkg::sidrl_req_t req,
   output logic block_start,
   output logic byte_take
);
   initial {req, block_start, byte_take} = '0;
   // Raises a request after an edge and drops it after the taking edge.
   task op(input logic w, r, s, t, input logic [7:0] i, d);
      @(posedge clock);
      #1 {req, block_start, byte_take} = {w, r, i, d, s, t};
      @(posedge clock);
      #1 {req, block_start, byte_take} = '0;
   endtask
endmodule

// *** bench/testbench.sv ***
`timescale 1ns/1ps
// Runs register reads and writes, a block read, reset and an enable pin.
module testbench;
   typedef struct packed {logic w; logic [7:0] i, d, e;} sidrl_row_t;
   logic clock = 1'h0;
   logic rst_n = 1'h0;
   logic [1:0] oe_n = 2'h3;
   sidrl_pkg::sidrl_req_t req;
   logic bs, bt, valid;
   logic [7:0] rdata;
   logic [4:0] len;
   logic [1:0] en;
   int miscompares = 0;
   int n_checks = 0;
   int c;
   sidrl_row_t rows[8] = '{'{1'h0, 8'h05, 8'h00, 8'h37}, '{1'h0, 8'h06, 8'h00, 8'h5A}, '{1'h0, 8'h07, 8'h00, 8'h08},
      '{1'h1, 8'h06, 8'hAA, 8'h5A}, '{1'h1, 8'h05, 8'hFF, 8'h37}, '{1'h1, 8'h08, 8'hFF, 8'h00},
      '{1'h1, 8'h07, 8'hFF, 8'h1F}, '{1'h1, 8'h07, 8'h03, 8'h03}};
   logic [7:0] bytes[4] = '{8'h37, 8'h5A, 8'h03, 8'h00};
   sidrl_host host (.clock(clock), .req(req), .block_start(bs), .byte_take(bt));
   sidrl_regs DUT (.clock(clock), .rst_n(rst_n), .req(req), .block_start(bs), .byte_take(bt), .oe_pin_n(oe_n),
      .rdata(rdata), .rdata_valid(valid), .readback_length(len), .diff_clock_out_en(en));
   always #50 clock = ~clock;
   task chk(input string n, input logic [7:0] s, e);
      n_checks++;
      if (s !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task give_verdict;
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Main sequence: row loop, block read, reset, enable latency.
   initial begin
      repeat (4) @(posedge clock);
      #1 rst_n = 1'h1;
      foreach (rows[k]) begin
         if (rows[k].w) host.op(1, 0, 0, 0, rows[k].i, rows[k].d);
         host.op(0, 1, 0, 0, rows[k].i, 8'h00);
         chk("read", rdata, rows[k].e);
      end
      host.op(0, 0, 1, 0, 8'h05, 8'h00);
      chk("count", rdata, 8'h03);
      foreach (bytes[k]) begin
         host.op(0, 0, 0, 1, 8'h00, 8'h00);
         chk("byte", rdata, bytes[k]);
      end
      host.op(0, 0, 0, 1, 8'h00, 8'h00);
      chk("valid", {7'h00, valid}, 8'h00);
      #1 rst_n = 1'h0;
      #1 chk("length", {3'h0, len}, 8'h08);
      @(posedge clock);
      #1 rst_n = 1'h1;
      oe_n = 2'h2;
      for (c = 0; c < 20 && en[0] !== 1'h1; c++) begin
         @(posedge clock);
         #1;
      end
      chk("latency", 8'(c >= 4 && c <= 12), 8'h01);
      chk("idle enable", {7'h00, en[1]}, 8'h00);
      oe_n = 2'h3;
      for (c = 0; c < 20 && en[0] !== 1'h0; c++) begin
         @(posedge clock);
         #1;
      end
      chk("off latency", 8'(c >= 4 && c <= 12), 8'h01);
      give_verdict;
   end
   // Watchdog well beyond the expected run of about 60 cycles.
   initial begin
      #200000;
      miscompares++;
      give_verdict;
   end
endmodule
